// File: rtl/s2_timing_regs.sv
`timescale 1ns/1ps
module s2_timing_regs (
   // clock and reset
   input  wire logic                              clock_in,
   input  wire logic                              resetn_in,
   // write port
   input  wire logic                              write_in,
   input  wire logic [xcvr_cfg_pkg::ADDR_W-1:0]   addr_in,
   input  wire logic [31:0]                       wdata_in,
   // stored timing
   output logic [xcvr_cfg_pkg::TOTAL_W-1:0]       line_total_out,
   output logic [xcvr_cfg_pkg::TOTAL_W-1:0]       frame_total_out,
   output logic                                   vsync_pol_out,
   output logic                                   hsync_pol_out,
   output logic [xcvr_cfg_pkg::SYNCW_W-1:0]       hsync_width_out,
   output logic [xcvr_cfg_pkg::SYNCW_W-1:0]       vsync_width_out,
   output logic [xcvr_cfg_pkg::TOTAL_W-1:0]       active_width_out,
   output logic [xcvr_cfg_pkg::TOTAL_W-1:0]       active_height_out
);

   logic [15:0] next_lt, next_ft, next_aw, next_ah;
   logic [14:0] next_hw, next_vw;
   logic        next_vp, next_hp;

   always_comb begin
      next_lt = line_total_out;
      next_ft = frame_total_out;
      next_vp = vsync_pol_out;
      next_hp = hsync_pol_out;
      next_hw = hsync_width_out;
      next_vw = vsync_width_out;
      next_aw = active_width_out;
      next_ah = active_height_out;
      if (write_in) begin
         case (addr_in)
            xcvr_cfg_pkg::OFS_LINE_TOTAL:  next_lt = wdata_in[15:0]; // RL10
            xcvr_cfg_pkg::OFS_FRAME_TOTAL: next_ft = wdata_in[15:0]; // RL11
            xcvr_cfg_pkg::OFS_POLARITY: begin
               next_vp = wdata_in[xcvr_cfg_pkg::POL_VS_BIT]; // RL12
               next_hp = wdata_in[xcvr_cfg_pkg::POL_HS_BIT]; // RL12
            end
            xcvr_cfg_pkg::OFS_HSYNC_WIDTH: next_hw = wdata_in[14:0]; // RL13
            xcvr_cfg_pkg::OFS_VSYNC_WIDTH: next_vw = wdata_in[14:0]; // RL14
            xcvr_cfg_pkg::OFS_ACT_WIDTH:   next_aw = wdata_in[15:0]; // RL15
            xcvr_cfg_pkg::OFS_ACT_HEIGHT:  next_ah = wdata_in[15:0]; // RL16
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         line_total_out    <= xcvr_cfg_pkg::TIMING_RESET;
         frame_total_out   <= xcvr_cfg_pkg::TIMING_RESET;
         vsync_pol_out     <= 1'b0;
         hsync_pol_out     <= 1'b0;
         hsync_width_out   <= xcvr_cfg_pkg::TIMING_RESET[14:0];
         vsync_width_out   <= xcvr_cfg_pkg::TIMING_RESET[14:0];
         active_width_out  <= xcvr_cfg_pkg::TIMING_RESET;
         active_height_out <= xcvr_cfg_pkg::TIMING_RESET;
      end else begin
         line_total_out    <= next_lt;
         frame_total_out   <= next_ft;
         vsync_pol_out     <= next_vp;
         hsync_pol_out     <= next_hp;
         hsync_width_out   <= next_hw;
         vsync_width_out   <= next_vw;
         active_width_out  <= next_aw;
         active_height_out <= next_ah;
      end
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);

   chk_line_total: assert property (write_in && addr_in == xcvr_cfg_pkg::OFS_LINE_TOTAL
                                    |=> line_total_out == $past(wdata_in[15:0])) // RL10
      else $error("line total not stored");
   chk_polarity: assert property (write_in && addr_in == xcvr_cfg_pkg::OFS_POLARITY
                                  |=> vsync_pol_out == $past(wdata_in[1])
                                      && hsync_pol_out == $past(wdata_in[0])) // RL12
      else $error("sync polarity bits misplaced");
   chk_hsync_width: assert property (write_in && addr_in == xcvr_cfg_pkg::OFS_HSYNC_WIDTH
                                     |=> hsync_width_out == $past(wdata_in[14:0])) // RL13
      else $error("hsync width not stored");

endmodule

// File: rtl/xcvr_cfg_pkg.sv
// Functional notes
// RL1: command word: port address bits 7..0, bit 15 one for write, zero for read.
// RL2: write data in command bits 31..16, used for writes only, ignored on reads.
// RL3: one command goes identically to every transceiver channel, no per-channel choice.
// RL4: read result captured into bits 15..0 when the port signals ready.
// RL5: software waits about ten bus clocks after a command before reading result.
// RL6: lock flag bit 0 high while the internal machine owns the port.
// RL7: software issues commands only while the lock flag reads zero.
// RL8: framing error, two bits per stream at bits 1:0, 9:8, 17:16, 25:24.
// RL9: framing error status is meaningful only with 32-bit transceiver data width.
// RL10: stream-two line total, bits 15..0, clocks per whole line.
// RL11: stream-two frame total, bits 15..0, lines per frame.
// RL12: stream-two polarity, vertical sync bit 1, horizontal sync bit 0.
// RL13: stream-two horizontal sync width, 15 bits, in clocks.
// RL14: stream-two vertical sync width, 15 bits, in lines.
// RL15: stream-two active pixels per line, bits 15..0.
// RL16: stream-two active lines per frame, bits 15..0.
// RL17: each command register write launches exactly one port transaction; writes while the sequencer is not idle launch none.
// RL18: read result changes only when a read completes, never on writes.
package xcvr_cfg_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int ADDR_W   = 12;
   localparam int DATA_W   = 32;
   localparam int NUM_CH   = 4;
   localparam int PADDR_W  = 8;
   localparam int PDATA_W  = 16;
   localparam int TOTAL_W  = 16;
   localparam int SYNCW_W  = 15;
   localparam int FE_W     = 2;
   localparam int FE_COUNT = 4;
   localparam int FE_STRIDE = 8;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_CMD         = 12'h2A0;
   localparam logic [11:0] OFS_READ_RESULT = 12'h2A4;
   localparam logic [11:0] OFS_LOCK        = 12'h2A8;
   localparam logic [11:0] OFS_FRAMING     = 12'h4FC;
   localparam logic [11:0] OFS_LINE_TOTAL  = 12'h500;
   localparam logic [11:0] OFS_FRAME_TOTAL = 12'h504;
   localparam logic [11:0] OFS_POLARITY    = 12'h508;
   localparam logic [11:0] OFS_HSYNC_WIDTH = 12'h50C;
   localparam logic [11:0] OFS_VSYNC_WIDTH = 12'h510;
   localparam logic [11:0] OFS_ACT_WIDTH   = 12'h514;
   localparam logic [11:0] OFS_ACT_HEIGHT  = 12'h518;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CMD_ADDR_LSB  = 0;
   localparam int CMD_DIR_BIT   = 15;
   localparam int CMD_WDATA_LSB = 16;
   localparam int LOCK_BIT      = 0;
   localparam int POL_HS_BIT    = 0;
   localparam int POL_VS_BIT    = 1;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] CMD_RESET    = 32'h0000_0000;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [15:0] TIMING_RESET = 16'h0000;
   localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;

   // ----------------------------------------------------------------
   // port sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      SEQ_IDLE        = 4'h1,
      SEQ_WAIT_UNLOCK = 4'h2,
      SEQ_ISSUE       = 4'h4,
      SEQ_WAIT_READY  = 4'h8
   } seq_state_type;

endpackage

// File: rtl/xcvr_cfg_regs.sv
`timescale 1ns/1ps
module xcvr_cfg_regs (
   // clock and reset
   input  wire logic                                  clock_in,
   input  wire logic                                  resetn_in,
   // register port
   input  wire logic                                  reg_write_in,
   input  wire logic                                  reg_read_in,
   input  wire logic [xcvr_cfg_pkg::ADDR_W-1:0]       reg_addr_in,
   input  wire logic [31:0]                           reg_wdata_in,
   output logic [31:0]                                reg_rdata_out,
   output logic                                       reg_rvalid_out,
   // transceiver reconfiguration port
   output logic [xcvr_cfg_pkg::NUM_CH-1:0]            xcvr_cfg_en_out,
   output logic                                       xcvr_cfg_we_out,
   output logic [xcvr_cfg_pkg::PADDR_W-1:0]           xcvr_cfg_addr_out,
   output logic [xcvr_cfg_pkg::PDATA_W-1:0]           xcvr_cfg_wdata_out,
   input  wire logic [xcvr_cfg_pkg::NUM_CH-1:0]       xcvr_cfg_ready_in,
   input  wire logic [xcvr_cfg_pkg::PDATA_W-1:0]      xcvr_cfg_rdata_in,
   // internal owner and receive status
   input  wire logic                                  internal_port_owner_in,
   input  wire logic [7:0]                            rx_framing_error_in,
   input  wire logic                                  xcvr_width32_in,
   // stream-two timing
   output logic [xcvr_cfg_pkg::TOTAL_W-1:0]           s2_line_total_out,
   output logic [xcvr_cfg_pkg::TOTAL_W-1:0]           s2_frame_total_out,
   output logic                                       s2_vsync_pol_out,
   output logic                                       s2_hsync_pol_out,
   output logic [xcvr_cfg_pkg::SYNCW_W-1:0]           s2_hsync_width_out,
   output logic [xcvr_cfg_pkg::SYNCW_W-1:0]           s2_vsync_width_out,
   output logic [xcvr_cfg_pkg::TOTAL_W-1:0]           s2_active_width_out,
   output logic [xcvr_cfg_pkg::TOTAL_W-1:0]           s2_active_height_out
);

   logic [31:0]                          xcvr_cfg_command;
   logic [31:0]                          next_command;
   logic                                 lock;
   logic                                 next_lock;
   logic [31:0]                          framing;
   logic [31:0]                          next_framing;
   logic [31:0]                          next_rdata;
   logic                                 next_rvalid;
   logic                                 cmd_write;
   logic                                 seq_idle;
   logic [xcvr_cfg_pkg::PDATA_W-1:0]     read_result;

   assign cmd_write = reg_write_in && (reg_addr_in == xcvr_cfg_pkg::OFS_CMD);

   // ----------------------------------------------------------------
   // command, lock and framing status
   // ----------------------------------------------------------------
   always_comb begin
      next_command = xcvr_cfg_command;
      if (cmd_write) begin
         next_command = reg_wdata_in; // RL1 RL2
      end
      next_lock    = internal_port_owner_in; // RL6
      next_framing = '0;
      for (int s = 0; s < xcvr_cfg_pkg::FE_COUNT; s++) begin
         // status only trusted with the 32-bit transceiver path
         if (xcvr_width32_in) begin
            next_framing[s*xcvr_cfg_pkg::FE_STRIDE +: xcvr_cfg_pkg::FE_W] =
               rx_framing_error_in[s*xcvr_cfg_pkg::FE_W +: xcvr_cfg_pkg::FE_W]; // RL8 RL9
         end
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         xcvr_cfg_command <= xcvr_cfg_pkg::CMD_RESET;
         lock             <= 1'b0;
         framing          <= xcvr_cfg_pkg::RDATA_RESET;
      end else begin
         xcvr_cfg_command <= next_command;
         lock             <= next_lock;
         framing          <= next_framing;
      end
   end

   // ----------------------------------------------------------------
   // port sequencer and timing store
   // ----------------------------------------------------------------
   xcvr_cfg_sequencer u_seq (
      .clock_in        (clock_in),
      .resetn_in       (resetn_in),
      .start_in        (cmd_write), // RL17
      .cmd_in          (reg_wdata_in),
      .lock_in         (lock), // RL7
      .idle_out        (seq_idle),
      .read_result_out (read_result),
      .port_en_out     (xcvr_cfg_en_out),
      .port_we_out     (xcvr_cfg_we_out),
      .port_addr_out   (xcvr_cfg_addr_out),
      .port_wdata_out  (xcvr_cfg_wdata_out),
      .port_ready_in   (xcvr_cfg_ready_in),
      .port_rdata_in   (xcvr_cfg_rdata_in)
   );

   s2_timing_regs u_timing (
      .clock_in          (clock_in),
      .resetn_in         (resetn_in),
      .write_in          (reg_write_in),
      .addr_in           (reg_addr_in),
      .wdata_in          (reg_wdata_in),
      .line_total_out    (s2_line_total_out),
      .frame_total_out   (s2_frame_total_out),
      .vsync_pol_out     (s2_vsync_pol_out),
      .hsync_pol_out     (s2_hsync_pol_out),
      .hsync_width_out   (s2_hsync_width_out),
      .vsync_width_out   (s2_vsync_width_out),
      .active_width_out  (s2_active_width_out),
      .active_height_out (s2_active_height_out)
   );

   // ----------------------------------------------------------------
   // read path, one cycle latency, unmapped reads return zero
   // ----------------------------------------------------------------
   always_comb begin
      next_rdata  = xcvr_cfg_pkg::RDATA_RESET;
      next_rvalid = reg_read_in;
      if (reg_read_in) begin
         case (reg_addr_in)
            xcvr_cfg_pkg::OFS_CMD:         next_rdata = xcvr_cfg_command;
            xcvr_cfg_pkg::OFS_READ_RESULT: next_rdata = {16'h0000, read_result}; // RL4
            xcvr_cfg_pkg::OFS_LOCK:        next_rdata = {31'h0000_0000, lock}; // RL6
            xcvr_cfg_pkg::OFS_FRAMING:     next_rdata = framing;
            xcvr_cfg_pkg::OFS_LINE_TOTAL:  next_rdata = {16'h0000, s2_line_total_out};
            xcvr_cfg_pkg::OFS_FRAME_TOTAL: next_rdata = {16'h0000, s2_frame_total_out};
            xcvr_cfg_pkg::OFS_POLARITY:
               next_rdata = {30'h0000_0000, s2_vsync_pol_out, s2_hsync_pol_out};
            xcvr_cfg_pkg::OFS_HSYNC_WIDTH: next_rdata = {17'h00000, s2_hsync_width_out};
            xcvr_cfg_pkg::OFS_VSYNC_WIDTH: next_rdata = {17'h00000, s2_vsync_width_out};
            xcvr_cfg_pkg::OFS_ACT_WIDTH:   next_rdata = {16'h0000, s2_active_width_out};
            xcvr_cfg_pkg::OFS_ACT_HEIGHT:  next_rdata = {16'h0000, s2_active_height_out};
            default:                       next_rdata = xcvr_cfg_pkg::RDATA_RESET;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_rdata_out  <= xcvr_cfg_pkg::RDATA_RESET;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rdata_out  <= next_rdata;
         reg_rvalid_out <= next_rvalid;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);

   sequence s_cmd_taken;
      cmd_write && seq_idle ##1 !lock;
   endsequence

   chk_cmd_launch: assert property (s_cmd_taken |=> &xcvr_cfg_en_out) // RL17
      else $error("command write did not launch a transaction");
   chk_cmd_fields: assert property (s_cmd_taken |=>
                                    xcvr_cfg_addr_out == $past(reg_wdata_in[7:0], 2)
                                    && xcvr_cfg_we_out == $past(reg_wdata_in[15], 2)) // RL1
      else $error("port address or direction wrong");
   chk_write_data: assert property (s_cmd_taken ##1 xcvr_cfg_we_out |->
                                    xcvr_cfg_wdata_out == $past(reg_wdata_in[31:16], 2)) // RL2
      else $error("port write data wrong");
   chk_locked_wait: assert property (cmd_write && seq_idle ##1 lock [*2]
                                     |-> xcvr_cfg_en_out == '0) // RL7
      else $error("port strobed while locked");
   chk_lock_flag: assert property (lock == $past(internal_port_owner_in)) // RL6
      else $error("lock flag does not follow internal owner");
   chk_frame_gate: assert property (!$past(xcvr_width32_in) |-> framing == '0) // RL9
      else $error("framing status shown without 32-bit path");
   chk_frame_lanes: assert property ($past(xcvr_width32_in) |->
                                     framing[9:8] == $past(rx_framing_error_in[3:2])
                                     && framing[25:24] == $past(rx_framing_error_in[7:6])) // RL8
      else $error("framing status lanes misplaced");

endmodule

// File: rtl/xcvr_cfg_sequencer.sv
`timescale 1ns/1ps
module xcvr_cfg_sequencer (
   // clock and reset
   input  wire logic                                  clock_in,
   input  wire logic                                  resetn_in,
   // command side
   input  wire logic                                  start_in,
   input  wire logic [31:0]                           cmd_in,
   input  wire logic                                  lock_in,
   output logic                                       idle_out,
   output logic [xcvr_cfg_pkg::PDATA_W-1:0]           read_result_out,
   // transceiver port
   output logic [xcvr_cfg_pkg::NUM_CH-1:0]            port_en_out,
   output logic                                       port_we_out,
   output logic [xcvr_cfg_pkg::PADDR_W-1:0]           port_addr_out,
   output logic [xcvr_cfg_pkg::PDATA_W-1:0]           port_wdata_out,
   input  wire logic [xcvr_cfg_pkg::NUM_CH-1:0]       port_ready_in,
   input  wire logic [xcvr_cfg_pkg::PDATA_W-1:0]      port_rdata_in
);

   xcvr_cfg_pkg::seq_state_type              state;
   xcvr_cfg_pkg::seq_state_type              next_state;
   logic [31:0]                              cmd;
   logic [31:0]                              next_cmd;
   logic [xcvr_cfg_pkg::NUM_CH-1:0]          seen;
   logic [xcvr_cfg_pkg::NUM_CH-1:0]          next_seen;
   logic [xcvr_cfg_pkg::PDATA_W-1:0]         result;
   logic [xcvr_cfg_pkg::PDATA_W-1:0]         next_result;
   logic                                     en;
   logic                                     next_en;
   logic                                     is_write;

   assign is_write = cmd[xcvr_cfg_pkg::CMD_DIR_BIT];

   // ----------------------------------------------------------------
   // transaction sequencing
   // ----------------------------------------------------------------
   always_comb begin
      next_state  = state;
      next_cmd    = cmd;
      next_seen   = seen;
      next_result = result;
      next_en     = 1'b0;
      case (state)
         xcvr_cfg_pkg::SEQ_IDLE: begin
            if (start_in) begin
               next_cmd   = cmd_in; // RL17
               next_seen  = '0;
               next_state = xcvr_cfg_pkg::SEQ_WAIT_UNLOCK;
            end
         end
         xcvr_cfg_pkg::SEQ_WAIT_UNLOCK: begin
            // hold off while the internal owner has the port
            if (!lock_in) begin
               next_en    = 1'b1;
               next_state = xcvr_cfg_pkg::SEQ_ISSUE;
            end
         end
         xcvr_cfg_pkg::SEQ_ISSUE,
         xcvr_cfg_pkg::SEQ_WAIT_READY: begin
            next_seen = seen | port_ready_in;
            if (port_ready_in[0] && !is_write) begin
               next_result = port_rdata_in; // RL4 RL18
            end
            if (&(seen | port_ready_in)) begin
               next_state = xcvr_cfg_pkg::SEQ_IDLE;
            end else begin
               next_state = xcvr_cfg_pkg::SEQ_WAIT_READY;
            end
         end
         default: begin
            next_state = xcvr_cfg_pkg::SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state  <= xcvr_cfg_pkg::SEQ_IDLE;
         cmd    <= xcvr_cfg_pkg::CMD_RESET;
         seen   <= '0;
         result <= xcvr_cfg_pkg::RESULT_RESET;
         en     <= 1'b0;
      end else begin
         state  <= next_state;
         cmd    <= next_cmd;
         seen   <= next_seen;
         result <= next_result;
         en     <= next_en;
      end
   end

   // ----------------------------------------------------------------
   // one strobe fanned to every channel
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < xcvr_cfg_pkg::NUM_CH; g++) begin : gen_ch
         assign port_en_out[g] = en; // RL3
      end
   endgenerate

   assign port_we_out     = is_write; // RL1
   assign port_addr_out   = cmd[xcvr_cfg_pkg::CMD_ADDR_LSB +: xcvr_cfg_pkg::PADDR_W]; // RL1
   assign port_wdata_out  = is_write ? cmd[xcvr_cfg_pkg::CMD_WDATA_LSB +: xcvr_cfg_pkg::PDATA_W]
                                     : '0; // RL2
   assign read_result_out = result;
   assign idle_out        = (state == xcvr_cfg_pkg::SEQ_IDLE);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);

   chk_same_strobe: assert property ((port_en_out == '0 && state != xcvr_cfg_pkg::SEQ_ISSUE)
                                     || (&port_en_out && state == xcvr_cfg_pkg::SEQ_ISSUE)) // RL3
      else $error("channel strobes differ");
   chk_single_strobe: assert property (port_en_out[0] |=> !port_en_out[0]) // RL17
      else $error("port strobe longer than one cycle");
   chk_read_capture: assert property ((state != xcvr_cfg_pkg::SEQ_IDLE) && !is_write
                                      && port_ready_in[0] && !port_en_out[0]
                                      |=> result == $past(port_rdata_in)) // RL4
      else $error("read data not captured on ready");
   chk_write_keeps: assert property ((state != xcvr_cfg_pkg::SEQ_IDLE) && is_write
                                     |=> $stable(result)) // RL18
      else $error("read result changed during write");

endmodule

// File: verification/xcvr_cfg_regs_tb.sv
`timescale 1ns/1ps
module xcvr_cfg_regs_tb;
   logic        clock_in = 0, resetn_in = 0, reg_write_in = 0, reg_read_in = 0;
   logic [11:0] reg_addr_in = 12'h000;
   logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
   logic        reg_rvalid_out, xcvr_cfg_we_out, internal_port_owner_in = 0;
   logic [3:0]  xcvr_cfg_en_out, xcvr_cfg_ready_in;
   logic [7:0]  xcvr_cfg_addr_out, rx_framing_error_in = 8'h00;
   logic [15:0] xcvr_cfg_wdata_out, xcvr_cfg_rdata_in, s2_line_total_out, s2_frame_total_out;
   logic [15:0] s2_active_width_out, s2_active_height_out;
   logic        s2_vsync_pol_out, s2_hsync_pol_out, xcvr_width32_in = 0;
   logic [14:0] s2_hsync_width_out, s2_vsync_width_out;
   int          num_errors = 0, samples_checked = 0, en_count = 0;
   always #12.5 clock_in = ~clock_in;
   always @(posedge clock_in) if (xcvr_cfg_en_out[0] === 1'b1) en_count++;
   xcvr_cfg_regs uut (.clock_in, .resetn_in, .reg_write_in, .reg_read_in, .reg_addr_in,
      .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .xcvr_cfg_en_out, .xcvr_cfg_we_out,
      .xcvr_cfg_addr_out, .xcvr_cfg_wdata_out, .xcvr_cfg_ready_in, .xcvr_cfg_rdata_in,
      .internal_port_owner_in, .rx_framing_error_in, .xcvr_width32_in, .s2_line_total_out,
      .s2_frame_total_out, .s2_vsync_pol_out, .s2_hsync_pol_out, .s2_hsync_width_out,
      .s2_vsync_width_out, .s2_active_width_out, .s2_active_height_out);
   xcvr_port_model port (.clock_in, .en_in(xcvr_cfg_en_out), .we_in(xcvr_cfg_we_out),
      .addr_in(xcvr_cfg_addr_out), .wdata_in(xcvr_cfg_wdata_out),
      .ready_out(xcvr_cfg_ready_in), .rdata_out(xcvr_cfg_rdata_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_in);
      reg_write_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge clock_in);
      reg_write_in <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clock_in);
      reg_read_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge clock_in);
      reg_read_in <= 1'b0;
      #1;
      chk({31'h0, reg_rvalid_out}, 32'h1);
      chk(reg_rdata_out, exp);
   endtask
   task automatic port_cmd(input logic [31:0] c, input logic [15:0] wd, input bit locked);
      int n;
      n = en_count;
      internal_port_owner_in <= locked;
      if (!locked) rd(12'h2A8, 32'h0);
      wr(12'h2A0, c);
      if (locked) begin
         repeat (8) @(posedge clock_in);
         rd(12'h2A8, 32'h1);
         chk(en_count - n, 0);
         internal_port_owner_in <= 1'b0;
      end
      for (int i = 0; i < 12 && xcvr_cfg_en_out !== 4'hF; i++) begin
         @(posedge clock_in);
         #1;
      end
      chk({xcvr_cfg_en_out, xcvr_cfg_we_out, xcvr_cfg_addr_out, xcvr_cfg_wdata_out},
          {3'h0, 4'hF, c[15], c[7:0], wd});
      repeat (10) @(posedge clock_in);
      chk(en_count - n, 1);
   endtask
   task automatic t_timing();
      logic [31:0] m [7] = '{32'hFFFF, 32'hFFFF, 32'h3, 32'h7FFF, 32'h7FFF, 32'hFFFF, 32'hFFFF};
      for (int i = 0; i < 7; i++) begin
         rd(12'h500 + 12'(4 * i), 32'h0);
         wr(12'h500 + 12'(4 * i), 32'hFFFF_FFFF);
         rd(12'h500 + 12'(4 * i), m[i]);
      end
      chk({31'h0, &{s2_line_total_out, s2_frame_total_out, s2_vsync_pol_out, s2_hsync_pol_out,
          s2_hsync_width_out, s2_vsync_width_out, s2_active_width_out,
          s2_active_height_out}}, 32'h1);
      wr(12'h508, 32'h2);
      #1;
      chk({30'h0, s2_vsync_pol_out, s2_hsync_pol_out}, 32'h2);
      rd(12'h2AC, 32'h0);
   endtask
   task automatic t_framing();
      rx_framing_error_in <= 8'hE4;
      xcvr_width32_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      rd(12'h4FC, 32'h0302_0100);
      xcvr_width32_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      rd(12'h4FC, 32'h0);
   endtask
   task automatic t_port();
      port_cmd(32'hBEEF_0037, 16'h0000, 1'b0);
      rd(12'h2A4, 32'h0000_C337);
      rd(12'h2A0, 32'hBEEF_0037);
      port_cmd(32'h1357_8037, 16'h1357, 1'b1);
      rd(12'h2A4, 32'h0000_C337);
      wr(12'h2A4, 32'hFFFF_FFFF);
      port_cmd(32'hFFFF_0037, 16'h0000, 1'b0);
      rd(12'h2A4, 32'h0000_1357);
      rd(12'h2A8, 32'h0);
   endtask
   task automatic results();
      $display("errors %0d comparisons %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clock_in);
      resetn_in <= 1'b1;
      t_timing();
      t_framing();
      t_port();
      results();
   end
   initial begin
      #30000;
      num_errors++;
      results();
   end
endmodule

// File: verification/xcvr_port_model.sv
`timescale 1ns/1ps
module xcvr_port_model (
   input  wire logic        clock_in,
   input  wire logic [3:0]  en_in,
   input  wire logic        we_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [15:0] wdata_in,
   output logic [3:0]       ready_out,
   output logic [15:0]      rdata_out
);
   logic [15:0] mem [256];
   int          cnt = 0;
   initial begin
      ready_out = 4'h0;
      rdata_out = 16'hFFFF;
      for (int i = 0; i < 256; i++) mem[i] = {8'hC3, 8'(i)};
   end
   // channels answer one after another, channel 0 last with the data
   always @(posedge clock_in) begin
      ready_out <= 4'h0;
      rdata_out <= ~rdata_out;
      if (en_in[0]) begin
         cnt <= 1;
         if (we_in) mem[addr_in] <= wdata_in;
      end else if (cnt != 0) begin
         ready_out[4 - cnt] <= 1'b1;
         cnt <= (cnt == 4) ? 0 : cnt + 1;
         if (cnt == 4) rdata_out <= mem[addr_in];
      end
   end
endmodule
